// [hdl/cit_pkg.sv]
package cit_pkg;

  // Byte lengths
  localparam logic [1:0] LEN_ONE = 2'h1;
  localparam logic [1:0] LEN_TWO = 2'h2;
  localparam logic [1:0] LEN_THREE = 2'h3;

  // Base cycle counts, one cycle per clock
  localparam logic [2:0] CYC_ONE = 3'h1;
  localparam logic [2:0] CYC_TWO = 3'h2;
  localparam logic [2:0] CYC_THREE = 3'h3;
  localparam logic [2:0] CYC_FOUR = 3'h4;
  localparam logic [2:0] CYC_IRQ_CALL = 3'h3;

  // Wait state field and total cycle width
  localparam int WAIT_W = 4;
  localparam int CYC_W = 5;
  localparam logic [CYC_W-1:0] CYC_RESET = 5'h01;
  localparam logic [15:0] PC_RESET = 16'h0000;

  // Opcode bytes of the covered instructions
  localparam logic [7:0] OP_MOV_DIR_RN = 8'h88;
  localparam logic [7:0] OP_MOV_RN_DIR = 8'ha8;
  localparam logic [7:0] OP_MOV_IND_IMM = 8'h76;
  localparam logic [7:0] OP_MOV_DIR_DIR = 8'h85;
  localparam logic [7:0] OP_MOV_DIR_IMM = 8'h75;
  localparam logic [7:0] OP_MOV_DPTR_IMM = 8'h90;
  localparam logic [7:0] OP_MOVC_DPTR = 8'h93;
  localparam logic [7:0] OP_MOVC_PC = 8'h83;
  localparam logic [7:0] OP_MOVX_RD_RI = 8'he2;
  localparam logic [7:0] OP_MOVX_RD_DPTR = 8'he0;
  localparam logic [7:0] OP_MOVX_WR_RI = 8'hf2;
  localparam logic [7:0] OP_MOVX_WR_DPTR = 8'hf0;
  localparam logic [7:0] OP_PUSH = 8'hc0;
  localparam logic [7:0] OP_POP = 8'hd0;
  localparam logic [7:0] OP_XCH_RN = 8'hc8;
  localparam logic [7:0] OP_XCH_IND = 8'hc6;
  localparam logic [7:0] OP_XCHD_IND = 8'hd6;
  localparam logic [7:0] OP_XCH_DIR = 8'hc5;
  localparam logic [7:0] OP_CLR_C = 8'hc3;
  localparam logic [7:0] OP_CLR_BIT = 8'hc2;
  localparam logic [7:0] OP_SETB_C = 8'hd3;
  localparam logic [7:0] OP_SETB_BIT = 8'hd2;
  localparam logic [7:0] OP_CPL_C = 8'hb3;
  localparam logic [7:0] OP_CPL_BIT = 8'hb2;
  localparam logic [7:0] OP_ANL_C_BIT = 8'h82;
  localparam logic [7:0] OP_ANL_C_NBIT = 8'hb0;
  localparam logic [7:0] OP_ORL_C_BIT = 8'h72;
  localparam logic [7:0] OP_ORL_C_NBIT = 8'ha0;
  localparam logic [7:0] OP_MOV_C_BIT = 8'ha2;
  localparam logic [7:0] OP_MOV_BIT_C = 8'h92;
  localparam logic [7:0] OP_JMP_IND = 8'h73;
  localparam logic [7:0] OP_RET = 8'h22;
  localparam logic [7:0] OP_RETI = 8'h32;
  localparam logic [7:0] OP_SJMP = 8'h80;
  localparam logic [7:0] OP_JC = 8'h40;
  localparam logic [7:0] OP_JNC = 8'h50;
  localparam logic [7:0] OP_JZ = 8'h60;
  localparam logic [7:0] OP_JNZ = 8'h70;
  localparam logic [7:0] OP_DJNZ_RN = 8'hd8;
  localparam logic [7:0] OP_LJMP = 8'h02;
  localparam logic [7:0] OP_LCALL = 8'h12;
  localparam logic [7:0] OP_JB = 8'h20;
  localparam logic [7:0] OP_JNB = 8'h30;
  localparam logic [7:0] OP_JBC = 8'h10;
  localparam logic [7:0] OP_CJNE_DIR = 8'hb5;
  localparam logic [7:0] OP_CJNE_IMM = 8'hb4;
  localparam logic [7:0] OP_CJNE_RN = 8'hb8;
  localparam logic [7:0] OP_CJNE_IND = 8'hb6;
  localparam logic [7:0] OP_DJNZ_DIR = 8'hd5;
  localparam logic [7:0] OP_NOP = 8'h00;

  // Masks for register, indirect and absolute forms
  localparam logic [7:0] MASK_RN = 8'hf8;
  localparam logic [7:0] MASK_RI = 8'hfe;
  localparam logic [7:0] MASK_ABS = 8'h1f;
  localparam logic [7:0] OP_AJMP = 8'h01;
  localparam logic [7:0] OP_ACALL = 8'h11;

  typedef struct packed {
    logic [7:0] opcode;
    logic [15:0] pc;
    logic irq_call;
  } cit_req_type;

  typedef struct packed {
    logic known;
    logic ext_data;
    logic [1:0] length;
    logic [CYC_W-1:0] cycles;
    logic [15:0] next_pc;
  } cit_resp_type;

endpackage : cit_pkg

// [hdl/cit_timing.sv]
// Behaviour
// - Each cycle count equals the same number of core clock periods.
// - External data move with zero wait states takes 4 cycles.
// - With n wait states external data moves take 4+n cycles.
// - Interrupt-inserted long call takes 3 cycles, not 4.
// - The four external data moves are 1 byte, 4 base cycles.
// - Both code table reads are 1 byte, 4 cycles.
// - Register/direct moves and immediate-to-indirect are 2 bytes, 2 cycles.
// - Direct-direct, immediate-direct, data pointer load: 3 bytes, 3 cycles.
// - Push and pop direct are 2 bytes, 2 cycles.
// - Exchanges: register 1/1, indirect 1/2, direct 2/2 bytes/cycles.
// - Carry ops and no-op 1/1; direct bit ops 2/2.
// - Indirect jump 1 byte 3 cycles; returns 1 byte 4 cycles.
// - Absolute, short, carry/zero jumps and register loop: 2 bytes, 3 cycles.
// - Long jump and normal long call: 3 bytes, 4 cycles.
// - Direct bit branches: 3 bytes, 4 cycles.
// - Compare branches and direct loop: 3 bytes, 4 cycles.
`timescale 1ns/1ps
module cit_timing (
  input wire logic CLK_SYS,
  input wire logic RST_N,
  input wire logic REQ_VALID,
  input wire cit_pkg::cit_req_type REQ,
  input wire logic [cit_pkg::WAIT_W-1:0] WAIT_STATES,
  output logic RESP_VALID,
  output cit_pkg::cit_resp_type RESP,
  output logic BUSY
);

  logic [7:0] op;
  logic is_rn;
  logic is_ri;
  logic is_abs;
  logic [1:0] len;
  logic [2:0] base;
  logic known;
  logic ext;
  logic [cit_pkg::CYC_W-1:0] total;
  logic [cit_pkg::CYC_W-1:0] cnt_q;
  logic [cit_pkg::CYC_W-1:0] cnt_d;
  logic resp_valid_q;
  cit_pkg::cit_resp_type resp_q;
  logic take;

  assign op = REQ.opcode;
  assign is_rn = ((op & cit_pkg::MASK_RN) == cit_pkg::OP_MOV_DIR_RN)
    || ((op & cit_pkg::MASK_RN) == cit_pkg::OP_MOV_RN_DIR)
    || ((op & cit_pkg::MASK_RN) == cit_pkg::OP_XCH_RN)
    || ((op & cit_pkg::MASK_RN) == cit_pkg::OP_DJNZ_RN)
    || ((op & cit_pkg::MASK_RN) == cit_pkg::OP_CJNE_RN);
  assign is_ri = ((op & cit_pkg::MASK_RI) == cit_pkg::OP_MOV_IND_IMM)
    || ((op & cit_pkg::MASK_RI) == cit_pkg::OP_XCH_IND)
    || ((op & cit_pkg::MASK_RI) == cit_pkg::OP_XCHD_IND)
    || ((op & cit_pkg::MASK_RI) == cit_pkg::OP_CJNE_IND)
    || ((op & cit_pkg::MASK_RI) == cit_pkg::OP_MOVX_RD_RI)
    || ((op & cit_pkg::MASK_RI) == cit_pkg::OP_MOVX_WR_RI);
  assign is_abs = ((op & cit_pkg::MASK_ABS) == cit_pkg::OP_AJMP)
    || ((op & cit_pkg::MASK_ABS) == cit_pkg::OP_ACALL);

  // Register and indirect forms collapse to their base opcode first
  logic [7:0] key;
  assign key = is_rn ? (op & cit_pkg::MASK_RN)
    : is_ri ? (op & cit_pkg::MASK_RI)
    : is_abs ? (op & cit_pkg::MASK_ABS)
    : op;

  always_comb
  begin
    len = cit_pkg::LEN_ONE;
    base = cit_pkg::CYC_ONE;
    known = 1'b1;
    ext = 1'b0;
    unique case (key)
      cit_pkg::OP_MOV_DIR_RN, cit_pkg::OP_MOV_RN_DIR, cit_pkg::OP_MOV_IND_IMM:
      begin
        len = cit_pkg::LEN_TWO;
        base = cit_pkg::CYC_TWO;
      end
      cit_pkg::OP_MOV_DIR_DIR, cit_pkg::OP_MOV_DIR_IMM, cit_pkg::OP_MOV_DPTR_IMM:
      begin
        len = cit_pkg::LEN_THREE;
        base = cit_pkg::CYC_THREE;
      end
      cit_pkg::OP_MOVC_DPTR, cit_pkg::OP_MOVC_PC:
      begin
        base = cit_pkg::CYC_FOUR;
      end
      cit_pkg::OP_MOVX_RD_RI, cit_pkg::OP_MOVX_RD_DPTR,
      cit_pkg::OP_MOVX_WR_RI, cit_pkg::OP_MOVX_WR_DPTR:
      begin
        base = cit_pkg::CYC_FOUR;
        ext = 1'b1;
      end
      cit_pkg::OP_PUSH, cit_pkg::OP_POP:
      begin
        len = cit_pkg::LEN_TWO;
        base = cit_pkg::CYC_TWO;
      end
      cit_pkg::OP_XCH_RN:
      begin
        base = cit_pkg::CYC_ONE;
      end
      cit_pkg::OP_XCH_IND, cit_pkg::OP_XCHD_IND:
      begin
        base = cit_pkg::CYC_TWO;
      end
      cit_pkg::OP_XCH_DIR:
      begin
        len = cit_pkg::LEN_TWO;
        base = cit_pkg::CYC_TWO;
      end
      cit_pkg::OP_CLR_C, cit_pkg::OP_SETB_C, cit_pkg::OP_CPL_C, cit_pkg::OP_NOP:
      begin
        base = cit_pkg::CYC_ONE;
      end
      cit_pkg::OP_CLR_BIT, cit_pkg::OP_SETB_BIT, cit_pkg::OP_CPL_BIT,
      cit_pkg::OP_ANL_C_BIT, cit_pkg::OP_ANL_C_NBIT, cit_pkg::OP_ORL_C_BIT,
      cit_pkg::OP_ORL_C_NBIT, cit_pkg::OP_MOV_C_BIT, cit_pkg::OP_MOV_BIT_C:
      begin
        len = cit_pkg::LEN_TWO;
        base = cit_pkg::CYC_TWO;
      end
      cit_pkg::OP_JMP_IND:
      begin
        base = cit_pkg::CYC_THREE;
      end
      cit_pkg::OP_RET, cit_pkg::OP_RETI:
      begin
        base = cit_pkg::CYC_FOUR;
      end
      cit_pkg::OP_AJMP, cit_pkg::OP_ACALL, cit_pkg::OP_SJMP, cit_pkg::OP_JC,
      cit_pkg::OP_JNC, cit_pkg::OP_JZ, cit_pkg::OP_JNZ, cit_pkg::OP_DJNZ_RN:
      begin
        len = cit_pkg::LEN_TWO;
        base = cit_pkg::CYC_THREE;
      end
      cit_pkg::OP_LJMP:
      begin
        len = cit_pkg::LEN_THREE;
        base = cit_pkg::CYC_FOUR;
      end
      // Vectored long call is one cycle shorter
      cit_pkg::OP_LCALL:
      begin
        len = cit_pkg::LEN_THREE;
        base = REQ.irq_call ? cit_pkg::CYC_IRQ_CALL : cit_pkg::CYC_FOUR;
      end
      cit_pkg::OP_JB, cit_pkg::OP_JNB, cit_pkg::OP_JBC, cit_pkg::OP_CJNE_DIR,
      cit_pkg::OP_CJNE_IMM, cit_pkg::OP_CJNE_RN, cit_pkg::OP_CJNE_IND,
      cit_pkg::OP_DJNZ_DIR:
      begin
        len = cit_pkg::LEN_THREE;
        base = cit_pkg::CYC_FOUR;
      end
      // Opcodes outside this table: flagged, timed as one byte, one cycle
      default:
      begin
        known = 1'b0;
      end
    endcase
  end

  // Wait states stretch only external data moves
  assign total = ext ? (cit_pkg::CYC_W'(base) + cit_pkg::CYC_W'(WAIT_STATES))
    : cit_pkg::CYC_W'(base);

  assign BUSY = (cnt_q != '0);
  assign take = REQ_VALID && !BUSY;

  // Answer after exactly the counted clocks
  assign cnt_d = take ? (total - cit_pkg::CYC_W'(1))
    : (BUSY ? cnt_q - cit_pkg::CYC_W'(1) : cnt_q);

  cit_pkg::cit_resp_type resp_d;
  always_comb
  begin
    resp_d.known = known;
    resp_d.ext_data = ext;
    resp_d.length = len;
    resp_d.cycles = total;
    resp_d.next_pc = REQ.pc + 16'(len);
  end

  always_ff @(posedge CLK_SYS or negedge RST_N)
  begin
    if (!RST_N)
    begin
      cnt_q <= '0;
      resp_valid_q <= 1'b0;
      resp_q <= '0;
    end
    else
    begin
      cnt_q <= cnt_d;
      resp_valid_q <= (take && total == cit_pkg::CYC_W'(1))
        || (cnt_q == cit_pkg::CYC_W'(1));
      if (take)
        resp_q <= resp_d;
    end
  end

  assign RESP_VALID = resp_valid_q;
  assign RESP = resp_q;

endmodule : cit_timing

// [bench/cit_timing_props.sv]
`timescale 1ns/1ps
module cit_timing_props (
  input wire logic CLK_SYS,
  input wire logic RST_N,
  input wire logic REQ_VALID,
  input wire cit_pkg::cit_req_type REQ,
  input wire logic [cit_pkg::WAIT_W-1:0] WAIT_STATES,
  input wire logic RESP_VALID,
  input wire cit_pkg::cit_resp_type RESP,
  input wire logic BUSY
);
  logic take;
  logic ext;
  logic [5:0] cnt_q;
  logic [5:0] cnt_d;
  assign take = REQ_VALID && !BUSY;
  assign ext = REQ.opcode inside {8'he0, 8'he2, 8'he3, 8'hf0, 8'hf2, 8'hf3};
  // Counts cycles since the take, zero when idle
  assign cnt_d = take ? 6'h01 : ((RESP_VALID || cnt_q == 6'h00) ? 6'h00 : cnt_q + 6'h01);
  always_ff @(posedge CLK_SYS or negedge RST_N)
    if (!RST_N)
      cnt_q <= 6'h00;
    else
      cnt_q <= cnt_d;
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);
  a_done_timing:
    assert property (RESP_VALID == (cnt_q != 6'h00 && cnt_q == {1'b0, RESP.cycles}))
    else $error("done pulse off its cycle count");
  a_busy_span:
    assert property (BUSY == (cnt_q != 6'h00 && cnt_q < {1'b0, RESP.cycles}))
    else $error("busy span wrong");
  a_next_pc:
    assert property (take |=> RESP.next_pc == $past(REQ.pc) + {14'h0000, RESP.length})
    else $error("next pc not pc plus length");
  a_ext_stretch:
    assert property (take && ext |=> RESP.ext_data
      && RESP.cycles == 5'h04 + {1'b0, $past(WAIT_STATES)})
    else $error("external move not stretched");
  a_ext_base:
    assert property (take && ext && WAIT_STATES == 4'h0 |=> RESP.cycles == 5'h04)
    else $error("external move base count wrong");
  a_irq_call:
    assert property (take && REQ.irq_call && REQ.opcode == 8'h12 |=> RESP.cycles == 5'h03)
    else $error("inserted call count wrong");
  a_long_flow:
    assert property (take && !REQ.irq_call && REQ.opcode inside {8'h02, 8'h12}
      |=> RESP.cycles == 5'h04 && RESP.length == 2'h3)
    else $error("long jump or call wrong");
  a_code_read:
    assert property (take && REQ.opcode inside {8'h93, 8'h83}
      |=> RESP.length == 2'h1 && RESP.cycles == 5'h04)
    else $error("code read wrong");
  c_irq: cover property (take && REQ.irq_call);
  c_b2b: cover property (take && RESP_VALID);
  c_max_wait: cover property (take && ext && WAIT_STATES == 4'hf);
endmodule : cit_timing_props
bind cit_timing cit_timing_props cit_timing_props_i (.CLK_SYS(CLK_SYS), .RST_N(RST_N),
  .REQ_VALID(REQ_VALID), .REQ(REQ), .WAIT_STATES(WAIT_STATES), .RESP_VALID(RESP_VALID),
  .RESP(RESP), .BUSY(BUSY));

// [bench/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic req_valid = 1'b0;
  cit_pkg::cit_req_type req = '0;
  logic [3:0] wait_states = 4'h0;
  logic resp_valid;
  cit_pkg::cit_resp_type resp;
  logic busy;
  int num_errors = 0;
  int samples_checked = 0;
  // Row: opcode, external flag in bit 7, length in [5:4], cycles in [3:0]
  logic [15:0] rows [62] = '{16'h8822, 16'ha822, 16'haf22, 16'h7622, 16'h7722, 16'h8533,
    16'h7533, 16'h9033, 16'h9314, 16'h8314, 16'he294, 16'he394, 16'he094, 16'hf294,
    16'hf394, 16'hf094, 16'hc022, 16'hd022, 16'hc811, 16'hcf11, 16'hc612, 16'hd712,
    16'hc522, 16'hc311, 16'hd311, 16'hb311, 16'h0011, 16'hc222, 16'hd222, 16'hb222,
    16'h8222, 16'hb022, 16'h7222, 16'ha022, 16'ha222, 16'h9222, 16'h7313, 16'h2214,
    16'h3214, 16'h0123, 16'he123, 16'h1123, 16'hf123, 16'h8023, 16'h4023, 16'h5023,
    16'h6023, 16'h7023, 16'hd823, 16'hdf23, 16'h0234, 16'h1234, 16'h2034, 16'h3034,
    16'h1034, 16'hb534, 16'hb434, 16'hb834, 16'hbf34, 16'hb634, 16'hb734, 16'hd534};
  always #12.5 clk_sys = ~clk_sys;
  cit_timing cit_timing_i (.CLK_SYS(clk_sys), .RST_N(rst_n), .REQ_VALID(req_valid),
    .REQ(req), .WAIT_STATES(wait_states), .RESP_VALID(resp_valid), .RESP(resp), .BUSY(busy));
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic finish_test();
    $display("Comparisons %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : finish_test
  task automatic issue(input logic [7:0] op, input logic irq, input logic [3:0] n);
    @(negedge clk_sys);
    req = '{opcode: op, pc: 16'hfff8 + {8'h00, op}, irq_call: irq};
    wait_states = n;
    req_valid = 1'b1;
    @(negedge clk_sys);
  endtask : issue
  // Bounded wait, k is the cycle of the done pulse
  task automatic wait_done(output int k);
    k = 1;
    while (resp_valid !== 1'b1 && k < 40)
    begin
      @(negedge clk_sys);
      k++;
    end
  endtask : wait_done
  task automatic run_op(input logic [7:0] op, input logic irq, input logic [3:0] n,
      input logic [1:0] el, input logic [4:0] ec, input logic [1:0] kx);
    int k;
    issue(op, irq, n);
    req_valid = 1'b0;
    wait_done(k);
    check("done_cycle", 32'(k), 32'(ec));
    check("cycles", 32'(resp.cycles), 32'(ec));
    check("length", 32'(resp.length), 32'(el));
    check("next_pc", 32'(resp.next_pc), 32'(req.pc + {14'h0000, el}));
    check("known_ext", 32'({resp.known, resp.ext_data}), 32'(kx));
  endtask : run_op
  initial
  begin
    repeat (5000) @(posedge clk_sys);
    num_errors++;
    finish_test();
  end
  initial
  begin
    int k;
    repeat (20) @(negedge clk_sys);
    check("reset_out", 32'({resp_valid, busy, resp}), 32'h0);
    rst_n = 1'b1;
    foreach (rows[i])
      run_op(rows[i][15:8], 1'b0, 4'h0, rows[i][5:4], {1'b0, rows[i][3:0]}, {1'b1, rows[i][7]});
    foreach (rows[i])
      for (int n = 1; n < 16 && rows[i][7]; n += 7)
        run_op(rows[i][15:8], 1'b0, 4'(n), 2'h1, 5'h04 + 5'(n), 2'h3);
    run_op(8'h12, 1'b1, 4'h0, 2'h3, 5'h03, 2'h2);
    run_op(8'ha5, 1'b0, 4'h0, 2'h1, 5'h01, 2'h0);
    // refusal while busy, then back to back
    issue(8'hf0, 1'b0, 4'h5);
    req.opcode = 8'h00;
    check("busy", 32'(busy), 32'h1);
    wait_done(k);
    check("held_cycle", 32'(k), 32'h9);
    check("held_resp", 32'(resp.cycles), 32'h9);
    @(negedge clk_sys);
    req_valid = 1'b0;
    check("b2b_done", 32'({resp_valid, resp.cycles}), 32'h21);
    // Reset in mid count must clear everything
    issue(8'he0, 1'b0, 4'hf);
    req_valid = 1'b0;
    repeat (3) @(negedge clk_sys);
    rst_n = 1'b0;
    @(negedge clk_sys);
    check("mid_reset", 32'({resp_valid, busy, resp}), 32'h0);
    rst_n = 1'b1;
    run_op(8'h00, 1'b0, 4'h0, 2'h1, 5'h01, 2'h2);
    finish_test();
  end
endmodule : tb_top
